/* File: include/dtb_pkg.sv */
// constants, states and helpers for the bus mastership handoff block
package dtb_pkg;

    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int CLK_PERIOD_NS  = 40;
    // address and strobe set-up ahead of the address strobe falling
    localparam int ADDR_SETUP_NS  = 35;
    // least time, so rounded up to whole cycles
    localparam int ADDR_SETUP_CYC = (ADDR_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // ------------------------------------------------------------
    // reset values of driven lines and of the set-up count
    // ------------------------------------------------------------
    localparam logic       AS_IDLE  = 1'h1;
    localparam logic [1:0] DS_IDLE  = 2'h3;
    localparam logic [3:0] CNT_ZERO = 4'h0;

    // ------------------------------------------------------------
    // state machines
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        ST_IDLE    = 6'h01,
        ST_ARB     = 6'h02,
        ST_WAIT_AS = 6'h04,
        ST_ADDR    = 6'h08,
        ST_DATA    = 6'h10,
        ST_END     = 6'h20
    } mst_state_t;

    typedef enum logic [2:0] {
        SL_IDLE = 3'h1,
        SL_BUSY = 3'h2,
        SL_ACK  = 3'h4
    } slv_state_t;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // true when at least one data strobe is low, whichever one it is
    function automatic logic ds_any_low(input logic [1:0] ds_n);
        return ~&ds_n;
    endfunction : ds_any_low

    // true when both data strobes are high again
    function automatic logic ds_all_high(input logic [1:0] ds_n);
        return &ds_n;
    endfunction : ds_all_high

endpackage : dtb_pkg

/* File: include/dtb_slave_if.sv */
// signals between the master logic and its slave responder
`timescale 1ns/10ps
interface dtb_slave_if;
    logic [1:0] ds_n;
    logic       hit;
    logic       ack;
    logic       dtack_oe;
    logic       req;

    modport host_side (
        output ds_n,
        output hit,
        output ack,
        input  dtack_oe,
        input  req
    );

    modport slv (
        input  ds_n,
        input  hit,
        input  ack,
        output dtack_oe,
        output req
    );
endinterface : dtb_slave_if

/* File: core/dtb_slave_resp.sv */
// slave responder for local and configuration register space
`timescale 1ns/10ps
module dtb_slave_resp
    import dtb_pkg::*;
(
    // clock and reset
    input  wire logic  i_core_clk,
    input  wire logic  i_rst,
    // link to the master logic
    dtb_slave_if.slv   sif
);

    slv_state_t state_q;
    logic       dtack_oe_q;
    logic       req_q;

    // ------------------------------------------------------------
    // handshake
    // ------------------------------------------------------------
    // ordinary slave handshake
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            state_q <= SL_IDLE;
        end
        else
        begin
            case (state_q)
                SL_IDLE:
                begin
                    if (sif.hit && ds_any_low(sif.ds_n))
                        state_q <= SL_BUSY;
                end
                SL_BUSY:
                begin
                    if (sif.ack)
                        state_q <= SL_ACK;
                end
                SL_ACK:
                begin
                    // wait for the last strobe, not the first
                    if (ds_all_high(sif.ds_n))
                        state_q <= SL_IDLE;
                end
                default:
                begin
                    state_q <= SL_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            dtack_oe_q <= 1'b0;
            req_q      <= 1'b0;
        end
        else
        begin
            req_q      <= (state_q == SL_IDLE) && sif.hit && ds_any_low(sif.ds_n);
            dtack_oe_q <= (state_q == SL_BUSY && sif.ack)
                          || (state_q == SL_ACK && !ds_all_high(sif.ds_n));
        end
    end

    assign sif.dtack_oe = dtack_oe_q;
    assign sif.req      = req_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_slave_req_issued: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (state_q == SL_IDLE && sif.hit && ds_any_low(sif.ds_n)) |=> sif.req)
        else $error("slave access not passed to local logic");

    a_dtack_held_strobe: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (sif.dtack_oe && ds_any_low(sif.ds_n)) |=> sif.dtack_oe)
        else $error("acknowledge dropped while a strobe is low");

    a_dtack_released: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (sif.dtack_oe && ds_all_high(sif.ds_n)) |=> !sif.dtack_oe)
        else $error("acknowledge kept after both strobes rose");

endmodule : dtb_slave_resp

/* File: core/dtb_mastership_handoff.sv */
// master-side acquisition and handover of the shared data transfer bus
`timescale 1ns/10ps
module dtb_mastership_handoff
    import dtb_pkg::*;
#(
    parameter int SETUP_CYC = ADDR_SETUP_CYC
)
(
    // clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    // local transfer requests
    input  wire logic       i_xfer_req,
    input  wire logic [1:0] i_xfer_ds_sel,
    input  wire logic       i_xfer_last,
    input  wire logic       i_early_release,
    output logic            o_xfer_done,
    output logic            o_xfer_err,
    output logic            o_own_bus,
    // requester and arbitration
    input  wire logic       i_bus_grant,
    output logic            o_bus_req,
    output logic            o_bbsy_o,
    output logic            o_bbsy_oe,
    // transfer bus as master
    input  wire logic       i_as_n,
    input  wire logic       i_dtack_n,
    input  wire logic       i_berr_n,
    output logic            o_as_o,
    output logic [1:0]      o_ds_o,
    output logic            o_lines_oe,
    // transfer bus as slave
    input  wire logic [1:0] i_ds_n,
    input  wire logic       i_slv_hit,
    input  wire logic       i_slv_ack,
    output logic            o_slv_req,
    output logic            o_dtack_o,
    output logic            o_dtack_oe
);

    // ------------------------------------------------------------
    // elaboration check
    // ------------------------------------------------------------
    if (SETUP_CYC < 1 || SETUP_CYC > 15)
    begin : g_bad_setup
        $error("SETUP_CYC must be 1 to 15");
    end

    localparam logic [3:0] SETUP_LIM = 4'(SETUP_CYC);

    mst_state_t state_q;
    logic [3:0] cnt_q;
    logic       grant_held_q;
    logic       last_q;
    logic       early_q;
    logic [1:0] ds_sel_q;
    logic       bbsy_oe_q;
    logic       lines_oe_q;
    logic       as_o_q;
    logic [1:0] ds_o_q;
    logic       done_q;
    logic       err_q;
    logic       acked;
    logic       bus_quiet;
    logic       take_bus;
    logic       start_cyc;
    logic       release_now;

    assign acked     = !i_dtack_n || !i_berr_n;
    assign bus_quiet = i_dtack_n && i_berr_n;
    // take the lines only once the old address strobe is high
    // no extra wait when it is already high
    assign take_bus  = (state_q == ST_WAIT_AS) && i_as_n;
    // address strobe falls only while the grant is held
    assign start_cyc = (state_q == ST_ADDR) && grant_held_q
                       && (cnt_q >= SETUP_LIM) && bus_quiet;
    // early release while the strobes are low
    // late release once the address strobe is back high
    assign release_now = last_q && bbsy_oe_q
                         && ((state_q == ST_DATA && early_q)
                             || (state_q == ST_END && !early_q));

    // ------------------------------------------------------------
    // sequencer
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            state_q <= ST_IDLE;
        end
        else
        begin
            case (state_q)
                ST_IDLE:
                begin
                    // without a held grant, arbitrate again first
                    if (i_xfer_req)
                        state_q <= grant_held_q ? ST_ADDR : ST_ARB;
                end
                ST_ARB:
                begin
                    if (i_bus_grant)
                        state_q <= ST_WAIT_AS;
                end
                ST_WAIT_AS:
                begin
                    if (take_bus)
                        state_q <= ST_ADDR;
                end
                ST_ADDR:
                begin
                    if (start_cyc)
                        state_q <= ST_DATA;
                end
                ST_DATA:
                begin
                    if (acked)
                        state_q <= ST_END;
                end
                ST_END:
                begin
                    state_q <= ST_IDLE;
                end
                default:
                begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // request details are latched when taken
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            last_q   <= 1'b0;
            early_q  <= 1'b0;
            ds_sel_q <= 2'h0;
        end
        else if (state_q == ST_IDLE && i_xfer_req)
        begin
            last_q   <= i_xfer_last;
            early_q  <= i_early_release;
            ds_sel_q <= i_xfer_ds_sel;
        end
    end

    // set-up count before the address strobe falls
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst || state_q != ST_ADDR)
            cnt_q <= CNT_ZERO;
        else if (cnt_q < SETUP_LIM)
            cnt_q <= cnt_q + 4'h1;
    end

    // ------------------------------------------------------------
    // grant held
    // ------------------------------------------------------------
    // set on grant, cleared with bus busy
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
            grant_held_q <= 1'b0;
        else if (state_q == ST_ARB && i_bus_grant)
            grant_held_q <= 1'b1;
        else if (release_now)
            grant_held_q <= 1'b0;
    end

    // ------------------------------------------------------------
    // bus drivers
    // ------------------------------------------------------------
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
            bbsy_oe_q <= 1'b0;
        else if (take_bus)
            bbsy_oe_q <= 1'b1;
        else if (release_now)
            bbsy_oe_q <= 1'b0;
    end

    // lines are kept driven between cycles while the bus is still ours
    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
            lines_oe_q <= 1'b0;
        else if (take_bus)
            lines_oe_q <= 1'b1;
        // early release lets every line go at transfer end
        else if (state_q == ST_END && !grant_held_q)
            lines_oe_q <= 1'b0;
        else if (state_q == ST_END && release_now)
            lines_oe_q <= 1'b0;
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            as_o_q <= AS_IDLE;
            ds_o_q <= DS_IDLE;
        end
        else if (start_cyc)
        begin
            as_o_q <= 1'b0;
            ds_o_q <= ~ds_sel_q;
        end
        else if (state_q == ST_DATA && acked)
        begin
            as_o_q <= AS_IDLE;
            ds_o_q <= DS_IDLE;
        end
    end

    always_ff @(posedge i_core_clk)
    begin
        if (i_rst)
        begin
            done_q <= 1'b0;
            err_q  <= 1'b0;
        end
        else
        begin
            done_q <= (state_q == ST_DATA) && !i_dtack_n;
            err_q  <= (state_q == ST_DATA) && i_dtack_n && !i_berr_n;
        end
    end

    assign o_bus_req   = (state_q == ST_ARB);
    assign o_bbsy_o    = 1'b0;
    assign o_bbsy_oe   = bbsy_oe_q;
    assign o_lines_oe  = lines_oe_q;
    assign o_as_o      = as_o_q;
    assign o_ds_o      = ds_o_q;
    assign o_xfer_done = done_q;
    assign o_xfer_err  = err_q;
    assign o_own_bus   = grant_held_q;

    // ------------------------------------------------------------
    // slave responder
    // ------------------------------------------------------------
    dtb_slave_if sif ();

    assign sif.ds_n = i_ds_n;
    assign sif.hit  = i_slv_hit;
    assign sif.ack  = i_slv_ack;
    assign o_slv_req  = sif.req;
    assign o_dtack_o  = 1'b0;
    assign o_dtack_oe = sif.dtack_oe;

    dtb_slave_resp u_resp (
        .i_core_clk (i_core_clk),
        .i_rst      (i_rst),
        .sif        (sif.slv)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_grant_before_as: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        $fell(as_o_q) |-> $past(grant_held_q) && lines_oe_q)
        else $error("address strobe fell without a grant");

    a_no_as_after_rel: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (!grant_held_q && as_o_q) |=> as_o_q)
        else $error("address strobe fell after bus busy release");

    a_wait_old_as: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        $rose(lines_oe_q) |-> $past(i_as_n))
        else $error("lines driven before old address strobe rose");

    a_early_release: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (state_q == ST_DATA && last_q && early_q && bbsy_oe_q) |=> !bbsy_oe_q)
        else $error("early bus busy release missed");

    a_late_release: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        ($fell(bbsy_oe_q) && !$past(early_q)) |-> $past(as_o_q))
        else $error("late release before address strobe rose");

    a_immediate_take: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (state_q == ST_WAIT_AS && i_as_n) |=> lines_oe_q && bbsy_oe_q
                                              && state_q == ST_ADDR)
        else $error("granted master waited with address strobe high");

    a_lines_let_go: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (state_q == ST_END && !grant_held_q) |=> !lines_oe_q ##1 !lines_oe_q)
        else $error("lines kept after early release");

    a_grant_flag: assert property (
        @(posedge i_core_clk) disable iff (i_rst)
        (state_q == ST_ARB && i_bus_grant) |=> grant_held_q [*2])
        else $error("grant flag not set on grant");

endmodule : dtb_mastership_handoff

/* File: tb/dtb_far_side.sv */
// far-side model: arbiter, remote slave and a competing master
`timescale 1ns/10ps
module dtb_far_side
(
    // clock and reset
    input  wire logic       i_core_clk,
    input  wire logic       i_rst,
    // scenario controls
    input  wire logic [7:0] i_grant_dly,
    input  wire logic       i_use_berr,
    input  wire logic       i_other_as,
    // device side
    input  wire logic       i_bus_req,
    input  wire logic       i_as_o,
    input  wire logic [1:0] i_ds_o,
    input  wire logic       i_lines_oe,
    input  wire logic       i_dtack_oe,
    // resolved bus levels
    output logic            o_bus_grant,
    output logic            o_as_n,
    output logic            o_dtack_n,
    output logic            o_berr_n
);
    logic [7:0] wait_q;
    logic [1:0] lat_q;
    logic       resp_q;

    // ------------------------------------------------------------
    // wired lines
    // ------------------------------------------------------------
    // released open-collector lines go to the pull-up, never the last value
    assign o_as_n    = (i_lines_oe ? i_as_o : 1'h1) & ~i_other_as;
    assign o_dtack_n = ~((resp_q & ~i_use_berr) | i_dtack_oe);
    assign o_berr_n  = ~(resp_q & i_use_berr);

    // ------------------------------------------------------------
    // arbiter and responding slave
    // ------------------------------------------------------------
    initial
    begin
        wait_q      = 8'h00;
        lat_q       = 2'h0;
        resp_q      = 1'h0;
        o_bus_grant = 1'h0;
    end

    always @(posedge i_core_clk)
    begin
        #1;
        if (i_rst || !i_bus_req)
        begin
            wait_q      = 8'h00;
            o_bus_grant = 1'h0;
        end
        else if (wait_q >= i_grant_dly)
            o_bus_grant = 1'h1;
        else
            wait_q = wait_q + 8'h01;
        if (i_rst || &i_ds_o)
        begin
            lat_q  = 2'h0;
            resp_q = 1'h0;
        end
        else if (i_lines_oe && !i_as_o && lat_q != 2'h2)
            lat_q = lat_q + 2'h1;
        else if (lat_q == 2'h2)
            resp_q = 1'h1;
    end
endmodule : dtb_far_side

/* File: tb/dtb_mastership_handoff_bench.sv */
// self-checking bench for the bus mastership handoff block
`timescale 1ns/10ps
module dtb_mastership_handoff_bench;
    import dtb_pkg::*;

`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin fail_count++; \
    $display("[ERR] %s exp=%0h got=%0h", nm, e, g); end end

    logic       i_core_clk, i_rst, i_xfer_req, i_xfer_last, i_early_release;
    logic [1:0] i_xfer_ds_sel, i_ds_n, cur_sel;
    logic       i_slv_hit, i_slv_ack, use_berr, other_as;
    logic [7:0] grant_dly;
    logic       o_xfer_done, o_xfer_err, o_own_bus, o_bus_req, o_bbsy_o, o_bbsy_oe;
    logic       o_as_o, o_lines_oe, o_slv_req, o_dtack_o, o_dtack_oe;
    logic [1:0] o_ds_o;
    logic       bus_grant, as_n, dtack_n, berr_n;
    int         fail_count, tests_run;

    dtb_mastership_handoff u_dut (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_xfer_req(i_xfer_req),
        .i_xfer_ds_sel(i_xfer_ds_sel), .i_xfer_last(i_xfer_last),
        .i_early_release(i_early_release), .o_xfer_done(o_xfer_done),
        .o_xfer_err(o_xfer_err), .o_own_bus(o_own_bus), .i_bus_grant(bus_grant),
        .o_bus_req(o_bus_req), .o_bbsy_o(o_bbsy_o), .o_bbsy_oe(o_bbsy_oe),
        .i_as_n(as_n), .i_dtack_n(dtack_n), .i_berr_n(berr_n), .o_as_o(o_as_o),
        .o_ds_o(o_ds_o), .o_lines_oe(o_lines_oe), .i_ds_n(i_ds_n),
        .i_slv_hit(i_slv_hit), .i_slv_ack(i_slv_ack), .o_slv_req(o_slv_req),
        .o_dtack_o(o_dtack_o), .o_dtack_oe(o_dtack_oe));

    dtb_far_side u_far (
        .i_core_clk(i_core_clk), .i_rst(i_rst), .i_grant_dly(grant_dly),
        .i_use_berr(use_berr), .i_other_as(other_as), .i_bus_req(o_bus_req),
        .i_as_o(o_as_o), .i_ds_o(o_ds_o), .i_lines_oe(o_lines_oe),
        .i_dtack_oe(o_dtack_oe), .o_bus_grant(bus_grant), .o_as_n(as_n),
        .o_dtack_n(dtack_n), .o_berr_n(berr_n));

    // ------------------------------------------------------------
    // shared tasks
    // ------------------------------------------------------------
    task automatic step();
        @(posedge i_core_clk);
        #1;
    endtask : step

    task automatic final_report();
        $display("checks %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : final_report

    task automatic go(input logic last, input logic early, input logic [1:0] sel);
        i_xfer_last     = last;
        i_early_release = early;
        i_xfer_ds_sel   = sel;
        cur_sel         = sel;
        i_xfer_req      = 1'h1;
    endtask : go

    // no address strobe and no driven lines for n cycles
    task automatic hold_idle(input int n);
        repeat (n)
        begin
            step();
            `CHK("as_o held", 1'h1, o_as_o)
            `CHK("lines_oe held", 1'h0, o_lines_oe)
        end
    endtask : hold_idle

    task automatic wait_done(input logic exp_err);
        int n;
        n = 0;
        while (o_xfer_done !== 1'h1 && o_xfer_err !== 1'h1)
        begin
            step();
            if (o_as_o === 1'h0)
                `CHK("ds_o", ~cur_sel, o_ds_o)
            n++;
            if (n > 60)
            begin
                fail_count++;
                $display("[ERR] transfer wait exp=1 got=0");
                final_report();
            end
        end
        `CHK("xfer_err", exp_err, o_xfer_err)
        `CHK("xfer_done", ~exp_err, o_xfer_done)
        i_xfer_req = 1'h0;
    endtask : wait_done

    // bus busy kept until the strobe is back high, then let go
    task automatic late_check();
        `CHK("bbsy late hold", 1'h1, o_bbsy_oe)
        `CHK("as high at end", 1'h1, o_as_o)
        step();
        `CHK("bbsy late drop", 1'h0, o_bbsy_oe)
        `CHK("grant flag clear", 1'h0, o_own_bus)
        `CHK("lines released", 1'h0, o_lines_oe)
        step();
    endtask : late_check

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_no_grant();
        grant_dly = 8'h0c;
        go(1'h0, 1'h0, 2'h1);
        hold_idle(8);
        wait_done(1'h0);
        step();
        `CHK("grant flag set", 1'h1, o_own_bus)
        $display("test no_grant done");
    endtask : t_no_grant

    task automatic t_held();
        logic [1:0] sels [2];
        sels = '{2'h2, 2'h3};
        foreach (sels[k])
        begin
            go(1'h0, 1'h0, sels[k]);
            step();
            `CHK("no re-arbitration", 1'h0, o_bus_req)
            wait_done(1'h0);
            step();
        end
        go(1'h1, 1'h0, 2'h3);
        wait_done(1'h0);
        late_check();
        $display("test held done");
    endtask : t_held

    task automatic t_takeover();
        int n;
        other_as  = 1'h1;
        grant_dly = 8'h00;
        go(1'h1, 1'h1, 2'h3);
        hold_idle(6);
        other_as = 1'h0;
        n        = 0;
        while (o_as_o !== 1'h0 && n < 20)
        begin
            step();
            n++;
        end
        if (o_as_o !== 1'h0)
        begin
            fail_count++;
            $display("[ERR] takeover start exp=0 got=1");
            final_report();
        end
        step();
        `CHK("bbsy early drop", 1'h0, o_bbsy_oe)
        `CHK("as still low", 1'h0, o_as_o)
        wait_done(1'h0);
        step();
        `CHK("lines off at end", 1'h0, o_lines_oe)
        step();
        $display("test takeover done");
    endtask : t_takeover

    task automatic t_rerequest();
        grant_dly = 8'h0f;
        go(1'h1, 1'h0, 2'h1);
        hold_idle(10);
        wait_done(1'h0);
        late_check();
        $display("test rerequest done");
    endtask : t_rerequest

    task automatic t_berr();
        use_berr  = 1'h1;
        grant_dly = 8'h01;
        go(1'h1, 1'h0, 2'h2);
        wait_done(1'h1);
        late_check();
        use_berr = 1'h0;
        $display("test berr done");
    endtask : t_berr

    task automatic t_slave();
        logic [1:0] firsts [2];
        firsts = '{2'h2, 2'h1};
        foreach (firsts[k])
        begin
            i_slv_hit = 1'h1;
            i_ds_n    = firsts[k];
            step();
            `CHK("slv_req", 1'h1, o_slv_req)
            i_ds_n = 2'h0;
            step();
            step();
            `CHK("no early dtack", 1'h0, o_dtack_oe)
            i_slv_ack = 1'h1;
            step();
            i_slv_ack = 1'h0;
            step();
            `CHK("dtack on", 1'h1, o_dtack_oe)
            i_ds_n = firsts[k];
            step();
            step();
            `CHK("dtack held", 1'h1, o_dtack_oe)
            i_ds_n    = 2'h3;
            i_slv_hit = 1'h0;
            step();
            step();
            `CHK("dtack off", 1'h0, o_dtack_oe)
        end
        $display("test slave done");
    endtask : t_slave

    // ------------------------------------------------------------
    // clock, reset and sequence
    // ------------------------------------------------------------
    initial
    begin
        i_core_clk = 1'h0;
        forever #20 i_core_clk = ~i_core_clk;
    end

    initial
    begin
        fail_count = 0;
        tests_run = 0;
        i_rst = 1'h1;
        i_xfer_req = 1'h0;
        i_xfer_ds_sel = 2'h3;
        cur_sel = 2'h3;
        i_xfer_last = 1'h0;
        i_early_release = 1'h0;
        i_ds_n = 2'h3;
        i_slv_hit = 1'h0;
        i_slv_ack = 1'h0;
        use_berr = 1'h0;
        other_as = 1'h0;
        grant_dly = 8'h00;
        repeat (10) step();
        i_rst = 1'h0;
        `CHK("reset as", AS_IDLE, o_as_o)
        `CHK("reset bbsy", 1'h0, o_bbsy_oe)
        `CHK("bbsy level", 1'h0, o_bbsy_o)
        `CHK("dtack level", 1'h0, o_dtack_o)
        `CHK("reset lines", 1'h0, o_lines_oe)
        t_no_grant();
        t_held();
        t_takeover();
        t_rerequest();
        t_berr();
        t_slave();
        final_report();
    end
endmodule : dtb_mastership_handoff_bench
